// >>> logic/fop_pkg.sv
// Purpose : shared constants and types of the flag offset programming block
// Assumes : one clock stands for both the write and the read clock
// Notes   : each offset is eighteen bits wide, split over low, mid and high registers
package fop_pkg;
    // ==========================================================
    // widths and depths
    localparam int DATA_W      = 9;
    localparam int FIFO_DEPTH  = 32;
    localparam int CNT_W       = 6;
    localparam int PTR_W       = 5;
    localparam int OFS_W       = 18;
    localparam int CMP_W       = 19;
    localparam int NUM_REGS    = 6;
    localparam int SERIAL_BITS = 36;
    localparam int HALF_BITS   = 18;
    localparam int LOW_W       = 8;
    localparam int MID_W       = 8;

    // ==========================================================
    // offset register indices, in programming order
    localparam logic [2:0] IDX_EMPTY_LOW  = 3'h0;
    localparam logic [2:0] IDX_EMPTY_HIGH = 3'h2;
    localparam logic [2:0] IDX_FULL_LOW   = 3'h3;
    localparam logic [2:0] IDX_FULL_HIGH  = 3'h5;
    localparam logic [DATA_W-1:0] BYTE_MASK = 9'h0FF;
    localparam logic [DATA_W-1:0] HIGH_MASK = 9'h003;

    // ==========================================================
    // reset values and timing
    localparam logic [OFS_W-1:0] DEFAULT_PARALLEL = 18'h0007F;
    localparam logic [OFS_W-1:0] DEFAULT_SERIAL   = 18'h003FF;
    localparam logic [5:0]       SERIAL_LAST      = 6'h23;
    localparam int               FLAG_VALID_EDGES = 2;
    localparam logic [CNT_W-1:0] FULL_COUNT       = CNT_W'(FIFO_DEPTH);
    localparam logic [CNT_W-1:0] HALF_COUNT       = CNT_W'(FIFO_DEPTH / 2);

    // ==========================================================
    // carriers
    typedef struct packed {
        logic ofs_sel_n;
        logic wr_strobe_n;
        logic rd_strobe_n;
        logic shift_strobe_n;
        logic serial_in;
    } fop_pins_t;

    typedef logic [NUM_REGS-1:0][DATA_W-1:0] fop_regs_t;
endpackage

// >>> logic/fop_top.sv
// Purpose : programmable almost-empty/almost-full offsets in front of a small FIFO
// Assumes : all pins synchronous to i_ref_clk; master and partial reset sampled
// Notes   : flags follow the pin polarities of the device (low-active flags end _n)
`timescale 1ns/1ps

// ==========================================================
// buffer
module fop_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_resetn,
    input  wire logic                     i_flush,
    input  wire logic                     i_in_valid,
    output logic                          o_in_ready,
    input  wire logic [WIDTH-1:0]         i_in_data,
    output logic                          o_out_valid,
    input  wire logic                     i_out_ready,
    output logic [WIDTH-1:0]              o_out_data,
    output logic [$clog2(DEPTH+1)-1:0]    o_count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wptr;
        logic [AW-1:0]               rptr;
        logic [CW-1:0]               count;
    } fop_fifo_state_t;

    fop_fifo_state_t st;
    fop_fifo_state_t next_st;
    logic            push;
    logic            pop;

    assign o_in_ready  = (st.count != CW'(DEPTH));
    assign o_out_valid = (st.count != '0);
    assign o_out_data  = st.mem[st.rptr];
    assign o_count     = st.count;
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wptr] = i_in_data;
            next_st.wptr         = (st.wptr == AW'(DEPTH - 1)) ? '0 : st.wptr + 1'b1;
        end
        if (pop) begin
            next_st.rptr = (st.rptr == AW'(DEPTH - 1)) ? '0 : st.rptr + 1'b1;
        end
        next_st.count = st.count + CW'(push) - CW'(pop);
        if (i_flush) begin
            next_st.wptr  = '0;
            next_st.rptr  = '0;
            next_st.count = '0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ==========================================================
// offset programming and flags
// How it works
// R01: master reset gives empty offset 127 for parallel, 1023 for serial loading
// R02: master reset gives full offset 127 for parallel, 1023 for serial loading
// R03: loading method is latched only during master reset
// R04: select low, write strobe low: input bus goes to next offset register
// R05: select low, read strobe low: next offset register goes to output bus
// R06: select and shift strobe low: one serial bit per edge, 36 bits total
// R07: select high: write strobe writes memory, read strobe reads memory
// R08: serial loading is all-or-nothing; flags valid after the last bit
// R09: select low with shift strobe high shifts nothing
// R10: memory writes may interleave serial loading; shifting resumes at next bit
// R11: serial loading pauses while select or shift strobe is high
// R12: flags become valid two edges after the completing write
// R13: offsets are never read back serially
// R14: parallel writes step through six registers and wrap to empty low
// R15: offset write and read pointers are separate and independent
// R16: master reset homes both pointers; partial reset keeps them
// R17: toggling write strobe pauses parallel loading; next write goes on
// R18: in parallel loading each flag is invalid until its offset is written
// R19: parallel reads step through the same six registers and wrap
// R20: interrupted offset reading resumes from the same read pointer
// R21: an offset read replaces the word held on the output bus
// R22: offset read-back works in both timing modes and both methods
// R23: fall-through: almost-empty goes high at n+2 words
// R24: fall-through: half-full goes low one word later than standard
// R25: fall-through: almost-full goes low one write later than standard
// R26: fall-through: capacity includes the output register word
// R27: each offset is low, mid and high registers joined into one threshold
module fop_top
    import fop_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_master_reset_n,
    input  wire logic              i_partial_reset_n,
    input  wire logic              i_fall_through_mode,
    input  wire logic              i_offset_load_select_n,
    input  wire logic              i_write_strobe_n,
    input  wire logic              i_read_strobe_n,
    input  wire logic              i_serial_shift_strobe_n,
    input  wire logic              i_serial_offset_in,
    input  wire logic [DATA_W-1:0] i_input_bus,
    output logic      [DATA_W-1:0] o_output_bus,
    output logic                   o_almost_empty_n,
    output logic                   o_almost_full_n,
    output logic                   o_half_full_n,
    output logic                   o_input_ready_flag,
    output logic                   o_output_ready_flag
);
    typedef struct packed {
        logic                serial_method;
        logic                fall_through;
        fop_regs_t           regs;
        logic [2:0]          wptr;
        logic [2:0]          rptr;
        logic [5:0]          sbit;
        logic                e_valid;
        logic                f_valid;
        logic [1:0]          e_pipe;
        logic [1:0]          f_pipe;
        logic                hold;
        logic [DATA_W-1:0]   out_bus;
        logic                pae_n;
        logic                paf_n;
        logic                hf_n;
        logic                ir;
        logic                orf;
    } fop_state_t;

    fop_state_t          st;
    fop_state_t          next_st;
    fop_pins_t           pins;
    logic                ofs_wr;
    logic                ofs_rd;
    logic                ser_sh;
    logic                mem_wr;
    logic                mem_rd;
    logic                consume;
    logic                flush;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic                fifo_out_ready;
    logic [DATA_W-1:0]   fifo_out_data;
    logic [CNT_W-1:0]    fifo_count;
    logic [CNT_W-1:0]    words;
    logic [CNT_W-1:0]    cap;
    logic [CMP_W-1:0]    n_ofs;
    logic [CMP_W-1:0]    m_ofs;

    // ==========================================================
    // helpers
    function automatic logic [DATA_W-1:0] reg_mask(input logic [2:0] idx);
        logic [2:0] pos;
        pos = (idx >= IDX_FULL_LOW) ? idx - IDX_FULL_LOW : idx;
        return (pos == IDX_EMPTY_HIGH) ? HIGH_MASK : BYTE_MASK;
    endfunction

    // R27: join low, mid, high
    function automatic logic [CMP_W-1:0] join_ofs(input fop_regs_t r, input logic [2:0] base);
        logic [OFS_W-1:0] v;
        v = {r[base + 3'h2][1:0], r[base + 3'h1][MID_W-1:0], r[base][LOW_W-1:0]};
        return {1'b0, v};
    endfunction

    function automatic fop_regs_t split_ofs(input logic [OFS_W-1:0] v);
        fop_regs_t r;
        r = '0;
        r[IDX_EMPTY_LOW]         = {1'b0, v[LOW_W-1:0]};
        r[IDX_EMPTY_LOW + 3'h1]  = {1'b0, v[LOW_W+MID_W-1:LOW_W]};
        r[IDX_EMPTY_HIGH]        = {7'h00, v[OFS_W-1:LOW_W+MID_W]};
        r[IDX_FULL_LOW]          = r[IDX_EMPTY_LOW];
        r[IDX_FULL_LOW + 3'h1]   = r[IDX_EMPTY_LOW + 3'h1];
        r[IDX_FULL_HIGH]         = r[IDX_EMPTY_HIGH];
        return r;
    endfunction

    function automatic logic [2:0] step6(input logic [2:0] p);
        return (p == IDX_FULL_HIGH) ? IDX_EMPTY_LOW : p + 3'h1;
    endfunction

    // ==========================================================
    // decode
    assign pins = '{ofs_sel_n:      i_offset_load_select_n,
                    wr_strobe_n:    i_write_strobe_n,
                    rd_strobe_n:    i_read_strobe_n,
                    shift_strobe_n: i_serial_shift_strobe_n,
                    serial_in:      i_serial_offset_in};

    // R04: parallel offset write, only under parallel method
    assign ofs_wr = !pins.ofs_sel_n && !pins.wr_strobe_n && pins.rd_strobe_n
                    && pins.shift_strobe_n && !st.serial_method;
    // R13: read-back is parallel only
    // R05: offset read in either method or timing mode
    // R22: no method gate on read-back
    assign ofs_rd = !pins.ofs_sel_n && pins.wr_strobe_n && !pins.rd_strobe_n
                    && pins.shift_strobe_n;
    // R06: serial shift, only under serial method
    // R09: shift strobe high blocks shifting
    assign ser_sh = !pins.ofs_sel_n && pins.wr_strobe_n && pins.rd_strobe_n
                    && !pins.shift_strobe_n && st.serial_method;
    // R07: select high routes the strobes to memory
    assign mem_wr = pins.ofs_sel_n && !pins.wr_strobe_n;
    assign mem_rd = pins.ofs_sel_n && !pins.rd_strobe_n;

    assign flush   = !i_master_reset_n || !i_partial_reset_n;
    assign consume = st.fall_through && st.hold && mem_rd;
    // an offset read owns the output bus, so the fall-through load waits a cycle
    assign fifo_out_ready = st.fall_through ? ((!st.hold || consume) && !ofs_rd) : mem_rd;

    // R26: fall-through capacity counts the output register
    assign words = fifo_count + CNT_W'(st.hold);
    assign cap   = FULL_COUNT + CNT_W'(st.fall_through);
    assign n_ofs = join_ofs(st.regs, IDX_EMPTY_LOW);
    assign m_ofs = join_ofs(st.regs, IDX_FULL_LOW);

    fop_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_resetn    (i_resetn),
        .i_flush     (flush),
        .i_in_valid  (mem_wr && !flush),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (i_input_bus),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_out_ready && !flush),
        .o_out_data  (fifo_out_data),
        .o_count     (fifo_count)
    );

    // ==========================================================
    // next state
    always_comb begin
        logic [5:0] k;
        logic [4:0] w;
        logic [2:0] idx;
        logic [3:0] b;
        // serial target bit, worked out every cycle so nothing is left unassigned
        k       = st.sbit;
        w       = (k >= 6'(HALF_BITS)) ? 5'(k - 6'(HALF_BITS)) : 5'(k);
        idx     = (k >= 6'(HALF_BITS)) ? IDX_FULL_LOW : IDX_EMPTY_LOW;
        idx     = idx + ((w >= 5'(LOW_W + MID_W)) ? 3'h2 : (w >= 5'(LOW_W)) ? 3'h1 : 3'h0);
        b       = (w >= 5'(LOW_W + MID_W)) ? 4'(w - 5'(LOW_W + MID_W)) :
                  (w >= 5'(LOW_W)) ? 4'(w - 5'(LOW_W)) : 4'(w);
        next_st = st;
        // R14: parallel write order and wrap
        // R17: pausing keeps the write pointer
        if (ofs_wr) begin
            next_st.regs[st.wptr] = i_input_bus & reg_mask(st.wptr);
            next_st.wptr          = step6(st.wptr);
            // R18: a flag is invalid from its low byte until its high byte
            if (st.wptr == IDX_EMPTY_LOW) begin
                next_st.e_valid = 1'b0;
            end
            if (st.wptr == IDX_FULL_LOW) begin
                next_st.f_valid = 1'b0;
            end
            if (st.wptr == IDX_EMPTY_HIGH) begin
                next_st.e_valid = 1'b1;
            end
            if (st.wptr == IDX_FULL_HIGH) begin
                next_st.f_valid = 1'b1;
            end
        end
        // R19: read order and wrap
        // R20: read pointer moves only on an offset read or a master reset
        // R21: read data overwrites the output bus
        // R15: read pointer apart from write pointer
        if (ofs_rd) begin
            next_st.out_bus = st.regs[st.rptr];
            next_st.rptr    = step6(st.rptr);
        end else if (fifo_out_valid && fifo_out_ready) begin
            next_st.out_bus = fifo_out_data;
        end
        if (st.fall_through && fifo_out_valid && fifo_out_ready) begin
            next_st.hold = 1'b1;
        end else if (consume) begin
            next_st.hold = 1'b0;
        end
        // R06: empty low bit first, full high bit last
        // R10: bit counter survives interleaved memory writes
        // R11: bit counter survives pauses
        if (ser_sh) begin
            next_st.regs[idx][b] = pins.serial_in;
            next_st.sbit = (st.sbit == SERIAL_LAST) ? 6'h00 : st.sbit + 6'h01;
            // R08: both flags invalid from first bit until the last
            if (st.sbit == 6'h00) begin
                next_st.e_valid = 1'b0;
                next_st.f_valid = 1'b0;
            end
            if (st.sbit == SERIAL_LAST) begin
                next_st.e_valid = 1'b1;
                next_st.f_valid = 1'b1;
            end
        end
        // R12: validity ripples through two edges
        next_st.e_pipe = {st.e_pipe[0], next_st.e_valid};
        next_st.f_pipe = {st.f_pipe[0], next_st.f_valid};
        // R23: fall-through adds one to the empty threshold
        next_st.pae_n = next_st.e_pipe[FLAG_VALID_EDGES-1]
                        && ({1'b0, {(CMP_W-CNT_W-1){1'b0}}, words} >
                            n_ofs + CMP_W'(st.fall_through));
        // R25: compare against capacity, one larger in fall-through
        next_st.paf_n = !(next_st.f_pipe[FLAG_VALID_EDGES-1]
                        && (CMP_W'(words) + m_ofs >= CMP_W'(cap)));
        // R24: half mark moves up by one in fall-through
        next_st.hf_n = !(words > HALF_COUNT + CNT_W'(st.fall_through));
        next_st.ir   = st.fall_through ? (words == cap) : (words != cap);
        next_st.orf  = st.fall_through ? !next_st.hold : (fifo_count != '0);
        if (!i_partial_reset_n) begin
            next_st.hold    = 1'b0;
            next_st.out_bus = '0;
        end
        // R03: method and timing mode latched only here
        // R01: empty default chosen by method
        // R02: full default chosen by method
        // R16: master reset homes both pointers
        if (!i_master_reset_n) begin
            next_st.serial_method = pins.ofs_sel_n;
            next_st.fall_through  = i_fall_through_mode;
            next_st.regs    = split_ofs(pins.ofs_sel_n ? DEFAULT_SERIAL : DEFAULT_PARALLEL);
            next_st.wptr    = IDX_EMPTY_LOW;
            next_st.rptr    = IDX_EMPTY_LOW;
            next_st.sbit    = 6'h00;
            next_st.e_valid = 1'b1;
            next_st.f_valid = 1'b1;
            next_st.hold    = 1'b0;
            next_st.out_bus = '0;
        end
        if (flush) begin
            next_st.pae_n = 1'b0;
            next_st.paf_n = 1'b1;
            next_st.hf_n  = 1'b1;
            next_st.ir    = !next_st.fall_through;
            next_st.orf   = next_st.fall_through;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st         <= '0;
            st.regs    <= split_ofs(DEFAULT_PARALLEL);
            st.e_valid <= 1'b1;
            st.f_valid <= 1'b1;
            st.e_pipe  <= 2'h3;
            st.f_pipe  <= 2'h3;
            st.paf_n   <= 1'b1;
            st.hf_n    <= 1'b1;
            st.ir      <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign o_output_bus        = st.out_bus;
    assign o_almost_empty_n    = st.pae_n;
    assign o_almost_full_n     = st.paf_n;
    assign o_half_full_n       = st.hf_n;
    assign o_input_ready_flag  = st.ir;
    assign o_output_ready_flag = st.orf;

    // ==========================================================
    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    a_method_latch: assert property ( // R03
        i_master_reset_n |=> $stable(st.serial_method))
        else $error("loading method changed outside master reset");
    a_empty_default: assert property ( // R01
        (!i_master_reset_n && !i_offset_load_select_n) |=> (n_ofs == CMP_W'(DEFAULT_PARALLEL)))
        else $error("empty offset default wrong");
    a_full_default: assert property ( // R02
        (!i_master_reset_n && i_offset_load_select_n) |=> (m_ofs == CMP_W'(DEFAULT_SERIAL)))
        else $error("full offset default wrong");
    a_write_wrap: assert property ( // R14
        (ofs_wr && st.wptr == IDX_FULL_HIGH && i_master_reset_n) |=> (st.wptr == IDX_EMPTY_LOW))
        else $error("offset write pointer did not wrap");
    a_shift_idle: assert property ( // R09
        (st.serial_method && !i_offset_load_select_n && i_serial_shift_strobe_n
         && i_master_reset_n)
        |=> $stable(st.sbit) && $stable(st.regs))
        else $error("serial bit moved without shift strobe");
    a_read_hold: assert property ( // R20
        (!ofs_rd && i_master_reset_n) |=> $stable(st.rptr))
        else $error("read pointer moved without offset read");
    a_read_data: assert property ( // R21
        (ofs_rd && i_master_reset_n && i_partial_reset_n)
        |=> (o_output_bus == $past(st.regs[st.rptr])))
        else $error("offset read did not reach output bus");
    a_partial_keep: assert property ( // R16
        (i_master_reset_n && !i_partial_reset_n && pins.ofs_sel_n)
        |=> $stable(st.wptr) && $stable(st.rptr) && $stable(st.regs))
        else $error("partial reset disturbed offsets");
    a_flag_delay: assert property ( // R12
        (ser_sh && st.sbit == SERIAL_LAST && i_master_reset_n)
        |=> !st.f_pipe[1] ##1 st.f_pipe[1])
        else $error("flag validity not two edges after completion");

    c_serial_done: cover property (ser_sh && st.sbit == SERIAL_LAST);
    c_write_wrap:  cover property (ofs_wr && st.wptr == IDX_FULL_HIGH);
    c_fifo_full:   cover property (words == cap);
    c_offset_read: cover property (ofs_rd ##1 ofs_rd);
endmodule

// >>> verif/fop_host.sv
// Purpose: host side of the offset and memory ports, driven by op codes
// Assumes: ops 0 idle 1 ofs wr 2 ofs rd 3 shift 4 mem wr 5 mem rd 6/7 pause
// Notes  : released bus shows the inverse of its last write, never a stale copy; released serial line shows the inverse of i_bit
`timescale 1ns/1ps
module fop_host
    import fop_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic [2:0]        i_op,
    input  wire logic [DATA_W-1:0] i_data,
    input  wire logic              i_bit,
    output fop_pins_t              o_pins,
    output logic      [DATA_W-1:0] o_input_bus
);
    // ==========================================================
    // pin patterns {select, write, read, shift}
    logic [DATA_W-1:0] last_bus = 9'h000;
    logic [3:0]        ctl;
    always_ff @(posedge i_ref_clk) begin
        if (!ctl[2]) begin
            last_bus <= i_data;
        end
    end
    always_comb begin
        case (i_op)
            3'h1: ctl = 4'h3;
            3'h2: ctl = 4'h5;
            3'h3: ctl = 4'h6;
            3'h4: ctl = 4'hB;
            3'h5: ctl = 4'hD;
            3'h6: ctl = 4'h7;
            3'h7: ctl = 4'hE;
            default: ctl = 4'hF;
        endcase
        o_pins      = {ctl, (i_op == 3'h3) ? i_bit : ~i_bit};
        o_input_bus = ctl[2] ? ~last_bus : i_data;
    end
endmodule

// >>> verif/fop_top_tb_top.sv
// Purpose: self-checking bench of fop_top against a queue model
// Assumes: host model turns op codes into pins within the same cycle
// Notes  : flags are compared only after they have had four edges to settle
`timescale 1ns/1ps
module fop_top_tb_top
    import fop_pkg::*;
;
    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic              mrst_n = 1'b1;
    logic              prst_n = 1'b1;
    logic              ft = 1'b0;
    logic              sbit = 1'b0;
    logic [2:0]        op = 3'h0;
    logic [DATA_W-1:0] dat = 9'h000;
    logic [DATA_W-1:0] ibus, obus, lastq;
    fop_pins_t         pins;
    logic              ae_n, af_n, hf_n, ir, orf;
    int                n_mismatch = 0;
    int                tests_run = 0;
    int                wp, rp, sc, cap;
    bit                ser, ftm;
    logic [DATA_W-1:0] regs [NUM_REGS];
    logic [DATA_W-1:0] q [$];
    always #2 clk = ~clk;
    fop_host host (.i_ref_clk(clk), .i_op(op), .i_data(dat), .i_bit(sbit), .o_pins(pins),
        .o_input_bus(ibus));
    fop_top dut (.i_ref_clk(clk), .i_resetn(rstn), .i_master_reset_n(mrst_n),
        .i_partial_reset_n(prst_n), .i_fall_through_mode(ft),
        .i_offset_load_select_n(pins.ofs_sel_n), .i_write_strobe_n(pins.wr_strobe_n),
        .i_read_strobe_n(pins.rd_strobe_n), .i_serial_shift_strobe_n(pins.shift_strobe_n),
        .i_serial_offset_in(pins.serial_in), .i_input_bus(ibus), .o_output_bus(obus),
        .o_almost_empty_n(ae_n), .o_almost_full_n(af_n), .o_half_full_n(hf_n),
        .o_input_ready_flag(ir), .o_output_ready_flag(orf));
    // ==========================================================
    // checks and model
    task automatic chk_bus(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_flg(string what, logic exp, logic got);
        chk_bus(what, {8'h00, exp}, {8'h00, got});
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    function automatic logic [DATA_W-1:0] msk(int i);
        return (i % 3 == 2) ? 9'h003 : 9'h0FF;
    endfunction
    function automatic int ofs(int b);
        return {regs[b + 2][1:0], regs[b + 1][7:0], regs[b][7:0]};
    endfunction
    task automatic drive(logic [2:0] c, logic [DATA_W-1:0] d, logic b);
        @(posedge clk);
        op   <= c;
        dat  <= d;
        sbit <= b;
    endtask
    task automatic idle(int k);
        drive(3'h0, 9'h000, 1'b0);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic flags();
        int w;
        w = q.size();
        if (ser && sc != 0) return;
        chk_flg("almost_empty", w > ofs(0) + ftm, ae_n);
        chk_flg("almost_full", !(w + ofs(3) >= cap), af_n);
        chk_flg("half_full", !(w > 16 + ftm), hf_n);
        chk_flg("input_ready", ftm ? w == cap : w != cap, ir);
        chk_flg("output_ready", ftm ? w == 0 : w != 0, orf);
    endtask
    task automatic mreset(bit s, bit f);
        logic [OFS_W-1:0] v;
        v = s ? 18'h003FF : 18'h0007F;
        drive(s ? 3'h7 : 3'h6, 9'h000, 1'b0);
        ft     <= f;
        mrst_n <= 1'b0;
        repeat (2) @(posedge clk);
        drive(3'h0, 9'h000, 1'b0);
        mrst_n <= 1'b1;
        for (int i = 0; i < NUM_REGS; i++) regs[i] = DATA_W'(v >> (8 * (i % 3))) & msk(i);
        {wp, rp, sc, ser, ftm, cap} = {32'd0, 32'd0, 32'd0, s, f, f ? 32'd33 : 32'd32};
        q.delete();
    endtask
    task automatic pw(logic [DATA_W-1:0] d);
        drive(3'h1, d, 1'b0);
        if (!ser) regs[wp] = d & msk(wp);
        if (!ser) wp = (wp + 1) % NUM_REGS;
    endtask
    task automatic ord();
        drive(3'h2, 9'h000, 1'b0);
        idle(0);
        chk_bus("offset_read", regs[rp], obus);
        lastq = regs[rp];
        rp = (rp + 1) % NUM_REGS;
    endtask
    task automatic sh(logic b);
        drive(3'h3, 9'h000, b);
        if (ser) regs[(sc / 18) * 3 + (sc % 18) / 8][(sc % 18) % 8] = b;
        if (ser) sc = (sc + 1) % SERIAL_BITS;
    endtask
    task automatic mem(bit rd, logic [DATA_W-1:0] d);
        drive(rd ? 3'h5 : 3'h4, d, 1'b0);
        if (!rd && q.size() < cap) q.push_back(d);
        if (rd && q.size() > 0) lastq = q.pop_front();
        idle(4);
        if (rd) chk_bus("memory_read", (ftm && q.size() > 0) ? q[0] : lastq, obus);
        flags();
    endtask
    // ==========================================================
    // tests
    initial begin
        #100000;
        n_mismatch++;
        results();
    end
    initial begin
        void'($urandom(69));
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        mreset(1'b0, 1'b0);
        repeat (NUM_REGS) ord();
        for (int i = 0; i < 7; i++) begin
            pw(DATA_W'($urandom));
            if (i == 3) drive(3'h6, 9'h000, 1'b0);
        end
        repeat (2) ord();
        @(posedge clk);
        prst_n <= 1'b0;
        repeat (2) @(posedge clk);
        prst_n <= 1'b1;
        repeat (7) ord();
        $display("test parallel pointers done");
        for (int f = 0; f < 2; f++) begin
            mreset(1'b0, f[0]);
            for (int i = 0; i < 6; i++) pw((i % 3) ? 9'h000 : DATA_W'(2 + $urandom % 5));
            for (int i = 0; i < 34; i++) mem(1'b0, DATA_W'($urandom));
            for (int i = 0; i < 34; i++) begin
                if (i == 5) ord();
                mem(1'b1, 9'h000);
            end
            $display("test flags mode %0d done", f);
        end
        mreset(1'b1, 1'b0);
        repeat (NUM_REGS) ord();
        pw(9'h155);
        for (int i = 0; i < SERIAL_BITS; i++) begin
            sh(1'($urandom));
            if (i == 9) mem(1'b0, DATA_W'($urandom));
            if (i == 20) drive(3'h6, 9'h000, 1'($urandom));
            if (i == 21) drive(3'h7, 9'h000, 1'($urandom));
        end
        mem(1'b0, DATA_W'($urandom));
        repeat (NUM_REGS) ord();
        $display("test serial done");
        results();
    end
endmodule
